// ### include/sidc_pkg.sv
// Purpose: Shared constants and types for the serial ID and low-power command block.
// Assumes: Control clock at 200 MHz; link clock is the host's serial clock.
// Notes:   Timing counts derive from times in ns; long ones are top-level parameters.
//
// How it works
// - Opcode 4Ch streams out the fixed 64-bit read-only unique identifier.
// - Unique identifier goes out byte 0 first, byte 7 last.
// - Eight-byte board serial store can be programmed exactly once.
// - Serial write takes eight bytes in a burst; chip select rise commits them.
// - Unprogrammed serial store reads back as all zero bytes.
// - Opcode C3h streams serial bytes, wrapping to byte 0 after byte 7.
// - Serial read goes out byte 0 first, byte 7 last.
// - Opcode BAh then chip select rise enters deep sleep after entry delay.
// - In deep sleep clock and data in are ignored, output floats.
// - Long enough chip select low pulse wakes deep sleep after exit delay.
// - Opcode B9h then chip select rise enters hibernate after entry delay.
// - In hibernate clock and data in are ignored, output floats.
// - Chip select fall leaves hibernate within exit delay; output floats meanwhile.
// - Stores are one 64-bit row, always accessed as a whole word.
// - Each byte shifts most significant bit first over eight clocks.

`default_nettype none

package sidc_pkg;

    // ------------------------------------------------------------------
    // Opcodes
    // ------------------------------------------------------------------
    localparam logic [7:0] READ_UNIQUE_IDENTIFIER_CMD = 8'h4C;
    localparam logic [7:0] WRITE_BOARD_SERIAL_CMD     = 8'hC2;
    localparam logic [7:0] READ_BOARD_SERIAL_CMD      = 8'hC3;
    localparam logic [7:0] DEEP_POWER_DOWN_CMD        = 8'hBA;
    localparam logic [7:0] HIBERNATE_CMD              = 8'hB9;

    // ------------------------------------------------------------------
    // Widths and field constants
    // ------------------------------------------------------------------
    localparam int             BYTE_W       = 8;
    localparam int             ID_W         = 64;
    localparam int             BIT_IDX_W    = 3;
    localparam int             SN_CNT_W     = 4;
    localparam int             CNT_W        = 20;
    localparam int             SYNC_W       = 2;
    localparam logic [1:0]     SYNC_INIT    = 2'h2;
    localparam logic [2:0]     BIT_LAST     = 3'h7;
    localparam logic [2:0]     BIT_ONE      = 3'h1;
    localparam logic [3:0]     SN_BYTES_CNT = 4'h8;
    localparam logic [3:0]     SN_CNT_ONE   = 4'h1;
    localparam logic [19:0]    CNT_ONE      = 20'h00001;
    localparam logic [63:0]    SN_DEFAULT   = 64'h0000000000000000;
    localparam int             ROW_COUNT    = 131072;
    localparam int             ROW_BITS     = 64;

    // ------------------------------------------------------------------
    // Timing: times in ns, counts in control clock cycles
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS                  = 5;
    localparam int DEEP_SLEEP_ENTRY_DELAY_NS      = 3000;
    localparam int DEEP_SLEEP_WAKE_PULSE_WIDTH_NS = 125;
    localparam int DEEP_SLEEP_EXIT_DELAY_NS       = 10000;
    localparam int HIBERNATE_ENTRY_DELAY_NS       = 3000;
    localparam int HIBERNATE_EXIT_DELAY_NS        = 450000;

    // Least times round up, longest times round down
    localparam logic [CNT_W-1:0] DSLP_ENTRY_CYC_DEF =
        CNT_W'((DEEP_SLEEP_ENTRY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] DSLP_PULSE_CYC =
        CNT_W'((DEEP_SLEEP_WAKE_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] DSLP_EXIT_CYC_DEF =
        CNT_W'(DEEP_SLEEP_EXIT_DELAY_NS / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] HIB_ENTRY_CYC_DEF =
        CNT_W'((HIBERNATE_ENTRY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] HIB_EXIT_CYC_DEF =
        CNT_W'(HIBERNATE_EXIT_DELAY_NS / CLK_PERIOD_NS);

    // ------------------------------------------------------------------
    // Power state machine
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_ACTIVE     = 3'h0,
        ST_DSLP_ENTER = 3'h1,
        ST_DSLP       = 3'h2,
        ST_DSLP_WAKE  = 3'h3,
        ST_HIB_ENTER  = 3'h4,
        ST_HIB        = 3'h5,
        ST_HIB_WAKE   = 3'h6
    } sidc_pwr_t;

endpackage

`default_nettype wire

// ### rtl/sidc_sync.sv
// Purpose: Two-stage synchroniser for levels entering the control clock domain.
// Assumes: Each bit is an independent level or a toggle.
// Notes:   First stage feeds only the second stage.

`timescale 1ns/1ps
`default_nettype none

module sidc_sync
#(
    parameter int           W    = 1,
    parameter logic [W-1:0] INIT = '0
)
(
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic [W-1:0]      q
);

    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] q_r;
    logic [W-1:0] q_nxt;

    // Next values of both stages
    always_comb
    begin
        meta_nxt = d;
        q_nxt    = meta_r;
    end

    // Stage registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_r <= INIT;
            q_r    <= INIT;
        end
        else
        begin
            meta_r <= meta_nxt;
            q_r    <= q_nxt;
        end
    end

    assign q = q_r;

endmodule

`default_nettype wire

// ### rtl/sidc_top.sv
// Purpose: Unique ID read, one-time serial number, deep sleep and hibernate commands.
// Assumes: SPI mode 0 on SCK; SCK runs only while CS_N is low.
// Notes:   Command effects and power state live on MCLK; shifting lives on SCK.

`timescale 1ns/1ps
`default_nettype none

module sidc_top
    import sidc_pkg::*;
#(
    parameter logic [CNT_W-1:0]  DSLP_ENTRY_CYC   = DSLP_ENTRY_CYC_DEF,
    parameter logic [CNT_W-1:0]  DSLP_EXIT_CYC    = DSLP_EXIT_CYC_DEF,
    parameter logic [CNT_W-1:0]  HIB_ENTRY_CYC    = HIB_ENTRY_CYC_DEF,
    parameter logic [CNT_W-1:0]  HIB_EXIT_CYC     = HIB_EXIT_CYC_DEF,
    parameter logic [ID_W-1:0]   UNIQUE_ID        = 64'h5A5A0F0F3C3CA5A5, // Arbitrary value
    parameter logic [BYTE_W-1:0] WRITE_ENABLE_CMD = 8'h06
)
(
    input  wire logic MCLK,
    input  wire logic RESET_N,
    input  wire logic SCK,
    input  wire logic CS_N,
    input  wire logic SI,
    output logic      SO,
    output logic      SO_OE,
    output logic      WRITE_EN_LATCH,
    output logic      SERIAL_PROGRAMMED,
    output logic      DEEP_SLEEP,
    output logic      HIBERNATE
);

    // ------------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------------
    function automatic logic is_read_cmd(input logic [BYTE_W-1:0] cmd);
        is_read_cmd = (cmd == READ_UNIQUE_IDENTIFIER_CMD) ||
                      (cmd == READ_BOARD_SERIAL_CMD);
    endfunction

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic                  frm_rst_n;
    logic [BIT_IDX_W-1:0]  bit_cnt_r;
    logic [BIT_IDX_W-1:0]  bit_cnt_nxt;
    logic [BYTE_W-2:0]     rx_sh_r;
    logic [BYTE_W-2:0]     rx_sh_nxt;
    logic                  op_done_r;
    logic                  op_done_nxt;
    logic [BIT_IDX_W-1:0]  dat_idx_r;
    logic [BIT_IDX_W-1:0]  dat_idx_nxt;
    logic [BYTE_W-1:0]     rx_byte;
    logic                  byte_end;
    logic [BYTE_W-1:0]     cmd_code_r;
    logic [BYTE_W-1:0]     cmd_code_nxt;
    logic                  cmd_tgl_r;
    logic                  cmd_tgl_nxt;
    logic [ID_W-1:0]       sn_stage_r;
    logic [ID_W-1:0]       sn_stage_nxt;
    logic [SN_CNT_W-1:0]   sn_cnt_r;
    logic [SN_CNT_W-1:0]   sn_cnt_nxt;
    logic [ID_W-1:0]       tx_word;
    logic [BYTE_W-1:0]     tx_byte;
    logic                  so_r;
    logic                  so_nxt;
    logic                  so_oe_r;
    logic                  so_oe_nxt;
    logic                  cs_s;
    logic                  tgl_s;
    logic                  cs_d_r;
    logic                  tgl_d_r;
    logic                  cs_rise;
    logic                  cs_fall;
    logic                  tgl_chg;
    logic                  awake;
    logic                  frame_end;
    sidc_pwr_t             state_r;
    sidc_pwr_t             state_nxt;
    logic [CNT_W-1:0]      cnt_r;
    logic [CNT_W-1:0]      cnt_nxt;
    logic                  pend_vld_r;
    logic                  pend_vld_nxt;
    logic [BYTE_W-1:0]     pend_cmd_r;
    logic [BYTE_W-1:0]     pend_cmd_nxt;
    logic                  wel_r;
    logic                  wel_nxt;
    logic                  sn_prog_r;
    logic                  sn_prog_nxt;
    logic [ID_W-1:0]       sn_store_r;
    logic [ID_W-1:0]       sn_store_nxt;

    // ------------------------------------------------------------------
    // Link side: frame state, cleared by chip select high
    // ------------------------------------------------------------------

    // Frame logic is held in reset outside frames, so a stopped SCK is harmless
    assign frm_rst_n = RESET_N & ~CS_N;

    // Shift in on rising SCK, byte boundary after eighth bit
    always_comb
    begin
        rx_byte     = {rx_sh_r, SI};
        byte_end    = (bit_cnt_r == BIT_LAST);
        bit_cnt_nxt = bit_cnt_r + BIT_ONE;
        rx_sh_nxt   = rx_byte[BYTE_W-2:0];
        op_done_nxt = op_done_r | byte_end;
        dat_idx_nxt = dat_idx_r;
        if (byte_end && op_done_r)
        begin
            dat_idx_nxt = dat_idx_r + BIT_ONE;
        end
    end

    always_ff @(posedge SCK or negedge frm_rst_n)
    begin
        if (!frm_rst_n)
        begin
            bit_cnt_r <= '0;
            rx_sh_r   <= '0;
            op_done_r <= 1'b0;
            dat_idx_r <= '0;
        end
        else
        begin
            bit_cnt_r <= bit_cnt_nxt;
            rx_sh_r   <= rx_sh_nxt;
            op_done_r <= op_done_nxt;
            dat_idx_r <= dat_idx_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Link side: results that must outlive the frame
    // ------------------------------------------------------------------

    // Opcode, its toggle event and the serial staging word survive CS high
    always_comb
    begin
        cmd_code_nxt = cmd_code_r;
        cmd_tgl_nxt  = cmd_tgl_r;
        sn_stage_nxt = sn_stage_r;
        sn_cnt_nxt   = sn_cnt_r;
        if (byte_end && !op_done_r)
        begin
            cmd_code_nxt = rx_byte;
            cmd_tgl_nxt  = ~cmd_tgl_r;
            sn_cnt_nxt   = '0;
        end
        else if (byte_end && (cmd_code_r == WRITE_BOARD_SERIAL_CMD) &&
                 (sn_cnt_r < SN_BYTES_CNT))
        begin
            sn_stage_nxt[sn_cnt_r[BIT_IDX_W-1:0]*BYTE_W +: BYTE_W] = rx_byte;
            sn_cnt_nxt = sn_cnt_r + SN_CNT_ONE;
        end
    end

    always_ff @(posedge SCK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            cmd_code_r <= '0;
            cmd_tgl_r  <= 1'b0;
            sn_stage_r <= '0;
            sn_cnt_r   <= '0;
        end
        else
        begin
            cmd_code_r <= cmd_code_nxt;
            cmd_tgl_r  <= cmd_tgl_nxt;
            sn_stage_r <= sn_stage_nxt;
            sn_cnt_r   <= sn_cnt_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Link side: output shifter on falling SCK
    // ------------------------------------------------------------------

    // Store only changes after a write frame ends, so it is steady in a read frame
    always_comb
    begin
        tx_word = (cmd_code_r == READ_UNIQUE_IDENTIFIER_CMD) ? UNIQUE_ID : sn_store_r;
        tx_byte = tx_word[dat_idx_r*BYTE_W +: BYTE_W];
        so_nxt    = tx_byte[~bit_cnt_r];
        so_oe_nxt = op_done_r && is_read_cmd(cmd_code_r);
    end

    always_ff @(negedge SCK or negedge frm_rst_n)
    begin
        if (!frm_rst_n)
        begin
            so_r    <= 1'b0;
            so_oe_r <= 1'b0;
        end
        else
        begin
            so_r    <= so_nxt;
            so_oe_r <= so_oe_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Crossing into the control clock
    // ------------------------------------------------------------------
    sidc_sync #(
        .W    (SYNC_W),
        .INIT (SYNC_INIT)
    ) u_sync (
        .clk   (MCLK),
        .rst_n (RESET_N),
        .d     ({CS_N, cmd_tgl_r}),
        .q     ({cs_s, tgl_s})
    );

    // ------------------------------------------------------------------
    // Control side: commands, serial store and power state
    // ------------------------------------------------------------------

    // Frames seen while not active are dropped whole
    always_comb
    begin
        cs_rise      = cs_s & ~cs_d_r;
        cs_fall      = ~cs_s & cs_d_r;
        tgl_chg      = tgl_s ^ tgl_d_r;
        awake        = (state_r == ST_ACTIVE);
        frame_end    = cs_rise && pend_vld_r && awake;
        state_nxt    = state_r;
        cnt_nxt      = cnt_r + CNT_ONE;
        pend_vld_nxt = pend_vld_r;
        pend_cmd_nxt = pend_cmd_r;
        wel_nxt      = wel_r;
        sn_prog_nxt  = sn_prog_r;
        sn_store_nxt = sn_store_r;
        // Opcode is steady by the time its toggle arrives here
        if (tgl_chg && awake)
        begin
            pend_vld_nxt = 1'b1;
            pend_cmd_nxt = cmd_code_r;
        end
        else if (cs_rise)
        begin
            pend_vld_nxt = 1'b0;
        end
        if (frame_end && (pend_cmd_r == WRITE_ENABLE_CMD))
        begin
            wel_nxt = 1'b1;
        end
        if (frame_end && (pend_cmd_r == WRITE_BOARD_SERIAL_CMD))
        begin
            wel_nxt = 1'b0;
            if (wel_r && (sn_cnt_r == SN_BYTES_CNT) && !sn_prog_r)
            begin
                sn_store_nxt = sn_stage_r;
                sn_prog_nxt  = 1'b1;
            end
        end
        case (state_r)
            ST_ACTIVE:
            begin
                if (frame_end && (pend_cmd_r == DEEP_POWER_DOWN_CMD))
                begin
                    state_nxt = ST_DSLP_ENTER;
                    cnt_nxt   = '0;
                end
                else if (frame_end && (pend_cmd_r == HIBERNATE_CMD))
                begin
                    state_nxt = ST_HIB_ENTER;
                    cnt_nxt   = '0;
                end
            end
            ST_DSLP_ENTER:
            begin
                if (cnt_r >= DSLP_ENTRY_CYC - CNT_ONE)
                begin
                    state_nxt = ST_DSLP;
                    cnt_nxt   = '0;
                end
            end
            ST_DSLP:
            begin
                // Short CS low pulses restart the width count
                if (cs_s)
                begin
                    cnt_nxt = '0;
                end
                else if (cnt_r >= DSLP_PULSE_CYC - CNT_ONE)
                begin
                    state_nxt = ST_DSLP_WAKE;
                    cnt_nxt   = '0;
                end
            end
            ST_DSLP_WAKE:
            begin
                if (cnt_r >= DSLP_EXIT_CYC - CNT_ONE)
                begin
                    state_nxt = ST_ACTIVE;
                end
            end
            ST_HIB_ENTER:
            begin
                if (cnt_r >= HIB_ENTRY_CYC - CNT_ONE)
                begin
                    state_nxt = ST_HIB;
                    cnt_nxt   = '0;
                end
            end
            ST_HIB:
            begin
                cnt_nxt = '0;
                if (cs_fall)
                begin
                    state_nxt = ST_HIB_WAKE;
                end
            end
            ST_HIB_WAKE:
            begin
                if (cnt_r >= HIB_EXIT_CYC - CNT_ONE)
                begin
                    state_nxt = ST_ACTIVE;
                end
            end
            default:
            begin
                state_nxt = ST_ACTIVE;
                cnt_nxt   = '0;
            end
        endcase
    end

    always_ff @(posedge MCLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            cs_d_r     <= 1'b1;
            tgl_d_r    <= 1'b0;
            state_r    <= ST_ACTIVE;
            cnt_r      <= '0;
            pend_vld_r <= 1'b0;
            pend_cmd_r <= '0;
            wel_r      <= 1'b0;
            sn_prog_r  <= 1'b0;
            sn_store_r <= SN_DEFAULT;
        end
        else
        begin
            cs_d_r     <= cs_s;
            tgl_d_r    <= tgl_s;
            state_r    <= state_nxt;
            cnt_r      <= cnt_nxt;
            pend_vld_r <= pend_vld_nxt;
            pend_cmd_r <= pend_cmd_nxt;
            wel_r      <= wel_nxt;
            sn_prog_r  <= sn_prog_nxt;
            sn_store_r <= sn_store_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------

    // Output floats whenever not fully awake, including entry and wake-up
    assign SO                = so_r;
    assign SO_OE             = so_oe_r & awake;
    assign WRITE_EN_LATCH    = wel_r;
    assign SERIAL_PROGRAMMED = sn_prog_r;
    assign DEEP_SLEEP        = (state_r == ST_DSLP);
    assign HIBERNATE         = (state_r == ST_HIB);

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RESET_N);

    a_float_asleep: assert property (!awake |-> !SO_OE)
        else $error("output driven while not active");
    a_dslp_start: assert property ((frame_end && pend_cmd_r == DEEP_POWER_DOWN_CMD)
        |=> state_r == ST_DSLP_ENTER && cnt_r == '0)
        else $error("deep sleep entry not started");
    a_hib_start: assert property ((frame_end && pend_cmd_r == HIBERNATE_CMD)
        |=> state_r == ST_HIB_ENTER)
        else $error("hibernate entry not started");
    a_hib_wake: assert property ((state_r == ST_HIB && cs_fall) |=> state_r == ST_HIB_WAKE)
        else $error("hibernate not left on chip select fall");
    a_hib_bound: assert property (state_r == ST_HIB_WAKE |-> cnt_r < HIB_EXIT_CYC)
        else $error("hibernate wake exceeds exit delay");
    a_dslp_pulse: assert property ((state_r == ST_DSLP && $rose(state_nxt == ST_DSLP_WAKE))
        |-> !cs_s && cnt_r >= DSLP_PULSE_CYC - CNT_ONE)
        else $error("deep sleep left without wake pulse");
    a_sn_commit: assert property ((frame_end && pend_cmd_r == WRITE_BOARD_SERIAL_CMD && wel_r
        && sn_cnt_r == SN_BYTES_CNT && !sn_prog_r)
        |=> sn_prog_r && sn_store_r == $past(sn_stage_r))
        else $error("serial write not committed");
    a_sn_needs_wel: assert property ((!wel_r && !sn_prog_r) |=> !sn_prog_r)
        else $error("serial programmed without write enable");
    a_wel_clear: assert property ((frame_end && pend_cmd_r == WRITE_BOARD_SERIAL_CMD)
        |=> !wel_r)
        else $error("write enable not cleared by write");
    a_sn_once: assert property (sn_prog_r |=> $stable(sn_store_r) && sn_prog_r)
        else $error("serial store changed after programming");
    a_sn_default: assert property (!sn_prog_r |-> sn_store_r == SN_DEFAULT)
        else $error("unprogrammed serial store not zero");
    a_first_byte: assert property (@(negedge SCK) disable iff (!frm_rst_n)
        (op_done_r && dat_idx_r == '0 && bit_cnt_r == '0 &&
         cmd_code_r == READ_UNIQUE_IDENTIFIER_CMD)
        |-> so_nxt == UNIQUE_ID[BYTE_W-1])
        else $error("unique id does not start with msb of byte 0");

    c_dslp: cover property (state_r == ST_DSLP ##1 state_r == ST_DSLP_WAKE);
    c_hib: cover property (state_r == ST_HIB ##1 state_r == ST_HIB_WAKE);
    c_sn_prog: cover property ($rose(sn_prog_r));
    c_read: cover property (SO_OE && is_read_cmd(pend_cmd_r));

endmodule

`default_nettype wire

// ### verification/sidc_host_model.sv
// Purpose: SPI host model that drives mode 0 frames into the command block.
// Assumes: 160 ns serial clock, running only inside frames.
// Notes:   Unused data bits toggle, so stale values never look valid.
`timescale 1ns/1ps
`default_nettype none
module sidc_host_model
(
    output logic      sck,
    output logic      cs_n,
    output logic      si,
    input  wire logic so,
    input  wire logic so_oe
);
    initial
    begin
        sck  = 1'b0;
        cs_n = 1'b1;
        si   = 1'b0;
    end
    // Opcode, nw write bytes (byte 0 first), then nr read bytes
    task automatic frame(input logic [7:0] op, input logic [63:0] wd, input int nw,
                         input int nr, output logic [71:0] rd, output int oe_n);
        int n;
        n    = 8 + 8 * (nw + nr);
        rd   = '0;
        oe_n = 0;
        // Off the control clock's edges, so the synchroniser sees no race
        #1;
        cs_n = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            if (i < 8)
                si = op[7 - i];
            else if (i < 8 + 8 * nw)
                si = wd[8 * (i / 8 - 1) + 7 - i % 8];
            else
                si = ~si;
            #80 sck = 1'b1;
            if (i >= 8 + 8 * nw)
            begin
                rd   = {rd[70:0], (so_oe === 1'b1) ? so : ~so}; // Floating line reads wrong
                oe_n += int'(so_oe === 1'b1);
            end
            #80 sck = 1'b0;
        end
        #80 cs_n = 1'b1;
        si = ~si;
        #237;
    endtask
    // Chip select alone, clock still: wake pulse
    task automatic pulse(input int ns);
        #1;
        cs_n = 1'b0;
        #(ns) cs_n = 1'b1;
        #237;
    endtask
endmodule
`default_nettype wire

// ### verification/testbench.sv
// Purpose: Self-checking bench for ID, serial store and low-power commands.
// Assumes: Shortened power counts keep the run brief.
// Notes:   Serial value is random from a fixed seed.
`timescale 1ns/1ps
`default_nettype none
module testbench
    import sidc_pkg::*;
;
    localparam logic [63:0] UID = 64'hC3A15E079B24D86F; // Arbitrary value
    logic        mclk, reset_n, sck, cs_n, si, so, so_oe, wel, prog, dslp, hib;
    logic [63:0] sn;
    int          n_errors, num_checks;
    // Entry delays at defaults; hibernate exit long enough to drop a wake frame
    sidc_top #(.DSLP_EXIT_CYC(20'h0001E), .HIB_EXIT_CYC(20'h00190), .UNIQUE_ID(UID)) u_sidc_top
    (.MCLK(mclk), .RESET_N(reset_n), .SCK(sck), .CS_N(cs_n), .SI(si), .SO(so),
        .SO_OE(so_oe), .WRITE_EN_LATCH(wel), .SERIAL_PROGRAMMED(prog),
        .DEEP_SLEEP(dslp), .HIBERNATE(hib));
    sidc_host_model u_sidc_host_model
    (.sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe));
    task automatic chk(input logic [71:0] got, input logic [71:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("errors=%0d checks=%0d", n_errors, num_checks);
        if (n_errors == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Expected read stream: byte 0 first, nine bytes so the wrap shows
    function automatic logic [71:0] stream(input logic [63:0] v);
        logic [71:0] e;
        e = '0;
        for (int k = 0; k < 9; k++)
            e = {e[63:0], v[8 * (k % 8) +: 8]};
        return e;
    endfunction
    task automatic rd(input logic [7:0] op, input logic [63:0] v);
        logic [71:0] r;
        int          o;
        u_sidc_host_model.frame(op, 64'h0, 0, 9, r, o);
        chk(r, stream(v));
        chk(72'(o), 72'h48);
    endtask
    // Write frame, then let the chip select rise cross over
    task automatic wr(input logic [7:0] op, input logic [63:0] v, input int nw);
        logic [71:0] r;
        int          o;
        u_sidc_host_model.frame(op, v, nw, 0, r, o);
        repeat (10) @(posedge mclk);
    endtask
    // Bounded wait for a power flag: sel 0 deep sleep, 1 hibernate
    task automatic wait_pwr(input int sel, input logic v);
        for (int i = 0; i < 1000; i++)
        begin
            @(posedge mclk);
            if ((sel != 0 ? hib : dslp) === v)
                return;
        end
        n_errors++;
        $display("mismatch t=%0t got=%h exp=%h", $time, {hib, dslp}, v);
        test_done();
    endtask
    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    initial
    begin
        n_errors   = 0;
        num_checks = 0;
        reset_n    = 1'b0;
        void'($urandom(47570));
        sn = {$urandom, $urandom};
        repeat (2) @(posedge mclk);
        #1 reset_n = 1'b1;
        repeat (10) @(posedge mclk);
        rd(READ_BOARD_SERIAL_CMD, SN_DEFAULT);
        rd(READ_UNIQUE_IDENTIFIER_CMD, UID);
        wr(WRITE_BOARD_SERIAL_CMD, sn, 8);
        chk(72'(prog), 72'h0);
        wr(8'h06, 64'h0, 0);
        chk(72'(wel), 72'h1);
        // Seven bytes only: nothing stored, latch still cleared
        wr(WRITE_BOARD_SERIAL_CMD, sn, 7);
        chk(72'({prog, wel}), 72'h0);
        wr(8'h06, 64'h0, 0);
        wr(WRITE_BOARD_SERIAL_CMD, sn, 8);
        chk(72'({prog, wel}), 72'h2);
        wr(8'h06, 64'h0, 0);
        wr(WRITE_BOARD_SERIAL_CMD, ~sn, 8);
        rd(READ_BOARD_SERIAL_CMD, sn);
        wr(DEEP_POWER_DOWN_CMD, 64'h0, 0);
        wait_pwr(0, 1'b1);
        chk(72'(so_oe), 72'h0);
        u_sidc_host_model.pulse(50);
        chk(72'(dslp), 72'h1);
        u_sidc_host_model.pulse(200);
        wait_pwr(0, 1'b0);
        chk(72'(so_oe), 72'h0);
        repeat (60) @(posedge mclk);
        rd(READ_UNIQUE_IDENTIFIER_CMD, UID);
        wr(HIBERNATE_CMD, 64'h0, 0);
        wait_pwr(1, 1'b1);
        chk(72'({so_oe, hib}), 72'h1);
        // Wake frame: its opcode lands during wake-up and must be dropped
        wr(8'h06, 64'h0, 0);
        chk(72'(wel), 72'h0);
        wait_pwr(1, 1'b0);
        repeat (120) @(posedge mclk);
        rd(READ_UNIQUE_IDENTIFIER_CMD, UID);
        test_done();
    end
endmodule
`default_nettype wire
